// ==== matrix_ctrl_pkg.sv ====
// constants and state layout for the matrix sync, shutdown and test control block
package matrix_ctrl_pkg;
    // clock and scan timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int SWITCH_SLOT_NS = 136000;
    localparam int SWITCH_SLOT_CYCLES = SWITCH_SLOT_NS / CLK_PERIOD_NS;
    localparam int LINE_COUNT = 12;
    localparam logic [3:0] LAST_LINE = 4'hB;
    localparam int DIV_W = 15;
    localparam logic [14:0] DIV_ONE = 15'h0001;

    // register pages and offsets
    localparam logic [1:0] PAGE_FUNCTION = 2'h3;
    localparam logic [7:0] CONFIG_OFFSET = 8'h00;
    localparam logic [7:0] PULLUP_SEL_OFFSET = 8'h0F;
    localparam logic [7:0] PULLDOWN_SEL_OFFSET = 8'h10;
    localparam logic [7:0] TEST_GATE_OFFSET = 8'hE0;
    localparam logic [7:0] ROW_HOLD_SELECT_OFFSET = 8'hE1;
    localparam logic [7:0] SINK_TRIM_OFFSET = 8'hE2;
    localparam logic [7:0] REFERENCE_OSC_TRIM_OFFSET = 8'hE3;

    // field positions
    localparam int SYNC_ROLE_MSB = 7;
    localparam int SYNC_ROLE_LSB = 6;
    localparam int SOFT_OFF_BIT_POS = 0;
    localparam int TEST_GATE_BIT_POS = 0;

    // reset values
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] PULLUP_SEL_RESET = 8'h00;
    localparam logic [7:0] PULLDOWN_SEL_RESET = 8'h00;
    localparam logic [7:0] TEST_REG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // row-hold field range
    localparam logic [3:0] ROW_HOLD_FIRST = 4'h1;
    localparam logic [3:0] ROW_HOLD_LAST = 4'hC;

    typedef enum logic [1:0] {
        ROLE_OFF_A = 2'b00,
        ROLE_MASTER = 2'b01,
        ROLE_SLAVE = 2'b10,
        ROLE_OFF_B = 2'b11
    } sync_role_e;

    // register access from the serial host interface
    typedef struct packed {
        logic wr;
        logic rd;
        logic [1:0] page;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } reg_rsp_s;

    typedef struct packed {
        logic [2:0] sink_trim;
        logic [3:0] reference_trim;
        logic [3:0] oscillator_trim;
    } trim_s;

    typedef struct packed {
        logic bus_rst_meta;
        logic bus_rst_sync;
        logic hw_off_meta;
        logic hw_off_sync;
        logic sync_meta;
        logic sync_sync;
        logic sync_prev;
        logic [7:0] config_reg;
        logic [7:0] pullup_sel_reg;
        logic [7:0] pulldown_sel_reg;
        logic test_gate_bit;
        logic [3:0] row_hold_field;
        trim_s trim;
        logic [DIV_W-1:0] div_cnt;
        logic [3:0] line;
        logic tick;
        logic sync_out;
        logic sync_oe;
        logic [11:0] sw_on;
        logic [11:0] sw_pullup;
        logic [11:0] cs_on;
        logic [11:0] cs_pulldown;
        logic analog_en;
        logic host_if_reset;
        reg_rsp_s rsp;
    } state_s;
endpackage : matrix_ctrl_pkg

// ==== matrix_sync_shutdown_test_ctrl.sv ====
// sync role, de-ghost, host interface reset, shutdown and guarded test registers
// What this block does and what the host must do
// R1 - sync role 01: master, drive own sync clock onto the sync pin.
// R2 - sync role 10: slave, take sync clock from the pin and follow it.
// R3 - sync role 00 or 11: sync pin high impedance, synchronisation off.
// R4 - sync role resets to 00, so the pin starts undriven.
// R5 - separate page-3 selects for switch pull-up and sink pull-down values.
// R6 - de-ghost resistors connect only while their line is off.
// R7 - serial host interface held in reset while bus reset pin is high.
// R8 - host keeps the bus reset pin low during normal traffic.
// R9 - all registers keep their contents in both shutdown modes.
// R10 - soft-off bit at 0 switches every current source off.
// R11 - every register stays readable and writable in software shutdown.
// R12 - hardware shutdown while the hardware-off pin is low, left when high.
// R13 - function registers stay reachable during hardware shutdown.
// R14 - test gate bit 0 blocks the three test data registers, 1 allows.
// R15 - row-hold 1..12 stops scanning, holds that switch on, floats others.
// R16 - host recovery: page 3, gate 01, clear test data, gate 01 again.
// R17 - host repeats the recovery writes periodically, say every 5 seconds.
// R18 - sink trim at bits 2:0; reference trim 7:4, oscillator trim 3:0.
// R19 - host leaves the trim fields at default in normal operation.
// R20 - slave takes scan timing from the received sync clock.
// R21 - host configures all slaves before setting one master.
module matrix_sync_shutdown_test_ctrl #(
    parameter int SLOT_CYCLES = matrix_ctrl_pkg::SWITCH_SLOT_CYCLES
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    // pins
    input wire logic I_BUS_RESET,
    input wire logic I_HW_OFF_N,
    input wire logic I_SYNC_IN,
    output logic O_SYNC_OUT,
    output logic O_SYNC_OE,
    // register access from the serial host interface
    input matrix_ctrl_pkg::reg_req_s I_REG_REQ,
    output matrix_ctrl_pkg::reg_rsp_s O_REG_RSP,
    output logic O_HOST_IF_RESET,
    // matrix drive
    input wire logic [11:0] I_CS_REQ,
    output logic [11:0] O_SW_ON,
    output logic [11:0] O_SW_PULLUP_EN,
    output logic [11:0] O_CS_ON,
    output logic [11:0] O_CS_PULLDOWN_EN,
    output logic [7:0] O_PULLUP_SEL,
    output logic [7:0] O_PULLDOWN_SEL,
    // timing and analog control
    output logic O_SCAN_TICK,
    output logic O_ANALOG_EN,
    output matrix_ctrl_pkg::trim_s O_TRIM
);
    import matrix_ctrl_pkg::*;

    localparam logic [DIV_W-1:0] SLOT_LAST = DIV_W'(SLOT_CYCLES - 1);

    state_s state_reg;
    state_s state_next;

    sync_role_e role;
    logic host_ok;
    logic page3;
    logic test_ok;
    logic own_tick;
    logic slave_tick;
    logic hold_active;
    logic [3:0] hold_line;
    logic currents_ok;

    always_comb begin
        role = sync_role_e'(state_reg.config_reg[SYNC_ROLE_MSB:SYNC_ROLE_LSB]);
        host_ok = !state_reg.bus_rst_sync; // R7
        page3 = (I_REG_REQ.page == PAGE_FUNCTION);
        test_ok = state_reg.test_gate_bit; // R14
        own_tick = (state_reg.div_cnt == SLOT_LAST);
        slave_tick = state_reg.sync_sync != state_reg.sync_prev;
        hold_active = (state_reg.row_hold_field >= ROW_HOLD_FIRST) && (state_reg.row_hold_field <= ROW_HOLD_LAST);
        hold_line = state_reg.row_hold_field - ROW_HOLD_FIRST;
        currents_ok = state_reg.config_reg[SOFT_OFF_BIT_POS] && state_reg.hw_off_sync; // R10
    end

    always_comb begin
        state_next = state_reg;
        // pin synchronisers
        state_next.bus_rst_meta = I_BUS_RESET;
        state_next.bus_rst_sync = state_reg.bus_rst_meta;
        state_next.hw_off_meta = I_HW_OFF_N;
        state_next.hw_off_sync = state_reg.hw_off_meta;
        state_next.sync_meta = I_SYNC_IN;
        state_next.sync_sync = state_reg.sync_meta;
        state_next.sync_prev = state_reg.sync_sync;

        state_next.host_if_reset = state_reg.bus_rst_sync; // R7
        state_next.analog_en = state_reg.hw_off_sync; // R12

        // register writes: no shutdown term gates them
        state_next.rsp.valid = 1'b0;
        if (host_ok && page3 && I_REG_REQ.wr) begin // R9 R11 R13
            unique case (I_REG_REQ.addr)
                CONFIG_OFFSET: state_next.config_reg = I_REG_REQ.wdata;
                PULLUP_SEL_OFFSET: state_next.pullup_sel_reg = I_REG_REQ.wdata; // R5
                PULLDOWN_SEL_OFFSET: state_next.pulldown_sel_reg = I_REG_REQ.wdata; // R5
                TEST_GATE_OFFSET: state_next.test_gate_bit = I_REG_REQ.wdata[TEST_GATE_BIT_POS];
                ROW_HOLD_SELECT_OFFSET: begin
                    if (test_ok) begin // R14
                        state_next.row_hold_field = I_REG_REQ.wdata[3:0];
                    end
                end
                SINK_TRIM_OFFSET: begin
                    if (test_ok) begin // R14
                        state_next.trim.sink_trim = I_REG_REQ.wdata[2:0]; // R18
                    end
                end
                REFERENCE_OSC_TRIM_OFFSET: begin
                    if (test_ok) begin // R14
                        state_next.trim.reference_trim = I_REG_REQ.wdata[7:4]; // R18
                        state_next.trim.oscillator_trim = I_REG_REQ.wdata[3:0]; // R18
                    end
                end
                default: begin
                end
            endcase
        end

        // register reads answer one cycle later; unmapped or blocked read zero
        if (host_ok && I_REG_REQ.rd) begin
            state_next.rsp.valid = 1'b1;
            state_next.rsp.data = READ_ZERO;
            if (page3) begin
                unique case (I_REG_REQ.addr)
                    CONFIG_OFFSET: state_next.rsp.data = state_reg.config_reg;
                    PULLUP_SEL_OFFSET: state_next.rsp.data = state_reg.pullup_sel_reg;
                    PULLDOWN_SEL_OFFSET: state_next.rsp.data = state_reg.pulldown_sel_reg;
                    TEST_GATE_OFFSET: state_next.rsp.data = {7'h00, state_reg.test_gate_bit};
                    ROW_HOLD_SELECT_OFFSET: begin
                        if (test_ok) begin // R14
                            state_next.rsp.data = {4'h0, state_reg.row_hold_field};
                        end
                    end
                    SINK_TRIM_OFFSET: begin
                        if (test_ok) begin // R14
                            state_next.rsp.data = {5'h00, state_reg.trim.sink_trim};
                        end
                    end
                    REFERENCE_OSC_TRIM_OFFSET: begin
                        if (test_ok) begin // R14
                            state_next.rsp.data = {state_reg.trim.reference_trim, state_reg.trim.oscillator_trim};
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // own slot divider
        if (own_tick) begin
            state_next.div_cnt = '0;
        end else begin
            state_next.div_cnt = state_reg.div_cnt + DIV_ONE;
        end

        // sync role
        state_next.tick = own_tick;
        state_next.sync_oe = 1'b0; // R3 R4
        unique case (role)
            ROLE_MASTER: begin
                state_next.sync_oe = 1'b1; // R1
                if (own_tick) begin
                    state_next.sync_out = !state_reg.sync_out; // R1
                end
            end
            ROLE_SLAVE: begin
                state_next.tick = slave_tick; // R2 R20
                state_next.div_cnt = '0;
            end
            ROLE_OFF_A, ROLE_OFF_B: begin
            end
        endcase

        // scan line advance, frozen while a row is held
        if (state_next.tick && !hold_active) begin // R15
            if (state_reg.line == LAST_LINE) begin
                state_next.line = 4'h0;
            end else begin
                state_next.line = state_reg.line + 4'h1;
            end
        end

        // switch and sink drive
        for (int i = 0; i < LINE_COUNT; i++) begin
            if (!state_reg.hw_off_sync) begin
                state_next.sw_on[i] = 1'b0; // R12
                state_next.sw_pullup[i] = 1'b0;
            end else if (hold_active) begin
                state_next.sw_on[i] = (hold_line == 4'(i)); // R15
                state_next.sw_pullup[i] = 1'b0; // R15
            end else begin
                state_next.sw_on[i] = (state_reg.line == 4'(i));
                state_next.sw_pullup[i] = (state_reg.line != 4'(i)); // R6
            end
            state_next.cs_on[i] = currents_ok && I_CS_REQ[i]; // R10
            state_next.cs_pulldown[i] = state_reg.hw_off_sync && !(currents_ok && I_CS_REQ[i]); // R6
        end
    end

    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_reg <= '0;
            state_reg.config_reg <= CONFIG_RESET; // R4
            state_reg.pullup_sel_reg <= PULLUP_SEL_RESET;
            state_reg.pulldown_sel_reg <= PULLDOWN_SEL_RESET;
            state_reg.row_hold_field <= TEST_REG_RESET[3:0];
            state_reg.trim.sink_trim <= TEST_REG_RESET[2:0];
            state_reg.trim.reference_trim <= TEST_REG_RESET[7:4];
            state_reg.trim.oscillator_trim <= TEST_REG_RESET[3:0];
            state_reg.rsp.data <= READ_ZERO;
        end else begin
            state_reg <= state_next;
        end
    end

    assign O_SYNC_OUT = state_reg.sync_out;
    assign O_SYNC_OE = state_reg.sync_oe;
    assign O_REG_RSP = state_reg.rsp;
    assign O_HOST_IF_RESET = state_reg.host_if_reset;
    assign O_SW_ON = state_reg.sw_on;
    assign O_SW_PULLUP_EN = state_reg.sw_pullup;
    assign O_CS_ON = state_reg.cs_on;
    assign O_CS_PULLDOWN_EN = state_reg.cs_pulldown;
    assign O_PULLUP_SEL = state_reg.pullup_sel_reg;
    assign O_PULLDOWN_SEL = state_reg.pulldown_sel_reg;
    assign O_SCAN_TICK = state_reg.tick;
    assign O_ANALOG_EN = state_reg.analog_en;
    assign O_TRIM = state_reg.trim;
endmodule : matrix_sync_shutdown_test_ctrl

// ==== matrix_ctrl_checker.sv ====
// port assertions for the matrix sync, shutdown and test control block
module matrix_ctrl_checker
    import matrix_ctrl_pkg::*;
#(
    parameter int SLOT_CYCLES = 8
) (
    // clock, reset and pins
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_BUS_RESET,
    input wire logic I_HW_OFF_N,
    input wire logic O_SYNC_OUT,
    input wire logic O_SYNC_OE,
    // register port
    input matrix_ctrl_pkg::reg_req_s I_REG_REQ,
    input matrix_ctrl_pkg::reg_rsp_s O_REG_RSP,
    input wire logic O_HOST_IF_RESET,
    // matrix drive, scan tick and analog enable
    input wire logic [11:0] I_CS_REQ,
    input wire logic [11:0] O_SW_ON,
    input wire logic [11:0] O_SW_PULLUP_EN,
    input wire logic [11:0] O_CS_ON,
    input wire logic [11:0] O_CS_PULLDOWN_EN,
    input wire logic O_SCAN_TICK,
    input wire logic O_ANALOG_EN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    property p_cs_gate; (O_CS_ON & ~$past(I_CS_REQ)) == 12'h000; endproperty
    a_cs_gate: assert property (p_cs_gate) else $error("sink on without request");
    property p_pullup_off; (O_SW_PULLUP_EN & O_SW_ON) == 12'h000; endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-up on a driven switch");
    property p_pulldown_off; (O_CS_PULLDOWN_EN & O_CS_ON) == 12'h000; endproperty
    a_pulldown_off: assert property (p_pulldown_off) else $error("pull-down on a driven sink");
    property p_host_reset; I_BUS_RESET [*4] |=> O_HOST_IF_RESET; endproperty
    a_host_reset: assert property (p_host_reset) else $error("host interface not held in reset");
    property p_rsp_quiet; O_HOST_IF_RESET && $past(O_HOST_IF_RESET) |-> !O_REG_RSP.valid; endproperty
    a_rsp_quiet: assert property (p_rsp_quiet) else $error("answer while bus reset");
    property p_hw_off; !I_HW_OFF_N [*4] |=> !O_ANALOG_EN && O_CS_ON == 12'h000 && O_SW_ON == 12'h000; endproperty
    a_hw_off: assert property (p_hw_off) else $error("outputs live in hardware shutdown");
    property p_sw_onehot; $onehot0(O_SW_ON) and (O_SCAN_TICK |=> !O_SCAN_TICK); endproperty
    a_sw_onehot: assert property (p_sw_onehot) else $error("switches or tick malformed");
    property p_sync_tick; O_SYNC_OE && $past(O_SYNC_OE) && $changed(O_SYNC_OUT) |-> O_SCAN_TICK; endproperty
    a_sync_tick: assert property (p_sync_tick) else $error("sync clock edge without slot tick");
endmodule : matrix_ctrl_checker

bind matrix_sync_shutdown_test_ctrl matrix_ctrl_checker #(.SLOT_CYCLES(SLOT_CYCLES)) u_chk (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_BUS_RESET(I_BUS_RESET), .I_HW_OFF_N(I_HW_OFF_N),
    .O_SYNC_OUT(O_SYNC_OUT), .O_SYNC_OE(O_SYNC_OE), .I_REG_REQ(I_REG_REQ), .O_REG_RSP(O_REG_RSP),
    .O_HOST_IF_RESET(O_HOST_IF_RESET), .I_CS_REQ(I_CS_REQ), .O_SW_ON(O_SW_ON),
    .O_SW_PULLUP_EN(O_SW_PULLUP_EN), .O_CS_ON(O_CS_ON), .O_CS_PULLDOWN_EN(O_CS_PULLDOWN_EN),
    .O_SCAN_TICK(O_SCAN_TICK), .O_ANALOG_EN(O_ANALOG_EN));

// ==== sync_clock_model.sv ====
// cascaded chip acting as sync master, feeding the sync pin
module sync_clock_model #(
    parameter int HALF = 20
) (
    // clock and enable
    input wire logic i_clk,
    input wire logic i_en,
    // sync pin level
    output logic o_sync
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_reg = 0;
    logic sync_reg = 1'b0;
    // stands still until enabled, so slaves are set up first
    always @(posedge i_clk) begin
        if (i_en && cnt_reg == HALF - 1) begin
            cnt_reg <= 0;
            sync_reg <= ~sync_reg;
        end else if (i_en) begin
            cnt_reg <= cnt_reg + 1;
        end
    end
    assign o_sync = sync_reg;
endmodule : sync_clock_model

// ==== matrix_sync_shutdown_test_ctrl_tb_top.sv ====
// testbench for the matrix sync, shutdown and test control block
module matrix_sync_shutdown_test_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import matrix_ctrl_pkg::*;
    typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_s;
    logic clk, rst_n, bus_reset, hw_off_n, sync_in, sync_out, sync_oe, host_rst, tick, analog_en, part_en;
    logic sync_seen;
    logic [11:0] cs_req, sw_on, sw_pu, cs_on, cs_pd;
    logic [7:0] pu_sel, pd_sel;
    reg_req_s req;
    reg_rsp_s rsp;
    trim_s trim;
    int num_errors = 0;
    int compares = 0;
    int g;
    row_s rows [8] = '{'{8'hE1, 8'h09, 8'h00}, '{8'hE0, 8'h01, 8'h01}, '{8'hE2, 8'h05, 8'h05},
        '{8'hE3, 8'hA5, 8'hA5}, '{8'h0F, 8'h3C, 8'h3C}, '{8'h10, 8'hC3, 8'hC3},
        '{8'hE1, 8'h03, 8'h03}, '{8'hE0, 8'h00, 8'h00}};
    logic [7:0] rec_addr [5] = '{8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hE0};
    logic [7:0] rec_data [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h01};

    matrix_sync_shutdown_test_ctrl #(.SLOT_CYCLES(8)) dut (.I_CLK(clk), .I_RESET_N(rst_n),
        .I_BUS_RESET(bus_reset), .I_HW_OFF_N(hw_off_n), .I_SYNC_IN(sync_in), .O_SYNC_OUT(sync_out),
        .O_SYNC_OE(sync_oe), .I_REG_REQ(req), .O_REG_RSP(rsp), .O_HOST_IF_RESET(host_rst),
        .I_CS_REQ(cs_req), .O_SW_ON(sw_on), .O_SW_PULLUP_EN(sw_pu), .O_CS_ON(cs_on),
        .O_CS_PULLDOWN_EN(cs_pd), .O_PULLUP_SEL(pu_sel), .O_PULLDOWN_SEL(pd_sel),
        .O_SCAN_TICK(tick), .O_ANALOG_EN(analog_en), .O_TRIM(trim));
    sync_clock_model #(.HALF(20)) partner (.i_clk(clk), .i_en(part_en), .o_sync(sync_in));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic give_verdict();
        $display("compares %0d, errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = {1'b1, 1'b0, PAGE_FUNCTION, a, d};
        @(negedge clk);
        req = '0;
        @(negedge clk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        int k;
        req = {1'b0, 1'b1, PAGE_FUNCTION, a, 8'h00};
        for (k = 0; k < 4; k++) begin
            @(negedge clk);
            req = '0;
            if (rsp.valid === 1'b1) break;
        end
        if (k == 4) begin
            num_errors++;
            give_verdict();
        end
        check(rsp.data, e);
        @(negedge clk);
    endtask : rd

    // cycles between two consecutive slot ticks
    task automatic tick_gap(output int gap);
        int k;
        int first;
        first = -1;
        gap = 0;
        for (k = 0; k < 200 && gap == 0; k++) begin
            @(negedge clk);
            if (tick === 1'b1 && first >= 0) gap = k - first;
            else if (tick === 1'b1) first = k;
        end
        if (gap == 0) begin
            num_errors++;
            give_verdict();
        end
    endtask : tick_gap

    initial begin
        rst_n = 1'b0;
        bus_reset = 1'b0;
        hw_off_n = 1'b1;
        cs_req = 12'hFFF;
        req = '0;
        part_en = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        rd(CONFIG_OFFSET, CONFIG_RESET);
        check(sync_oe, 16'h0000);
        check(cs_on, 16'h0000);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rows[i].e);
        end
        check(trim, 16'h05A5);
        check({pd_sel, pu_sel}, 16'hC33C);
        rd(8'hE1, 8'h00);
        repeat (40) @(negedge clk);
        check(sw_on, 16'h0004);
        check(sw_pu, 16'h0000);
        repeat (2) begin
            foreach (rec_addr[i]) wr(rec_addr[i], rec_data[i]);
        end
        check(trim, 16'h0000);
        $display("register table test done");
        for (int r = 0; r < 4; r++) begin
            wr(CONFIG_OFFSET, {r[1:0], 6'h01});
            repeat (4) @(negedge clk);
            check(sync_oe, {15'h0000, r == 1});
            check(cs_on, 16'h0FFF);
            check(cs_pd, 16'h0000);
            check(sw_pu, {4'h0, ~sw_on});
        end
        wr(CONFIG_OFFSET, 8'h41);
        tick_gap(g);
        check(g[15:0], 16'h0008);
        sync_seen = sync_out;
        repeat (8) @(negedge clk);
        check(sync_out, {15'h0000, !sync_seen});
        wr(CONFIG_OFFSET, 8'h81);
        part_en = 1'b1;
        tick_gap(g);
        check(g[15:0], 16'h0014);
        $display("sync role test done");
        hw_off_n = 1'b0;
        repeat (5) @(negedge clk);
        check(analog_en, 16'h0000);
        check(cs_on, 16'h0000);
        check(sw_on, 16'h0000);
        check(sw_pu, 16'h0000);
        rd(CONFIG_OFFSET, 8'h81);
        wr(PULLUP_SEL_OFFSET, 8'h11);
        rd(PULLUP_SEL_OFFSET, 8'h11);
        hw_off_n = 1'b1;
        repeat (5) @(negedge clk);
        check(analog_en, 16'h0001);
        wr(CONFIG_OFFSET, 8'h80);
        repeat (3) @(negedge clk);
        check(cs_on, 16'h0000);
        check(cs_pd, 16'h0FFF);
        rd(PULLUP_SEL_OFFSET, 8'h11);
        $display("shutdown test done");
        bus_reset = 1'b1;
        repeat (5) @(negedge clk);
        check(host_rst, 16'h0001);
        wr(PULLUP_SEL_OFFSET, 8'h22);
        req = {1'b0, 1'b1, PAGE_FUNCTION, PULLUP_SEL_OFFSET, 8'h00};
        @(negedge clk);
        check(rsp.valid, 16'h0000);
        req = '0;
        @(negedge clk);
        bus_reset = 1'b0;
        repeat (5) @(negedge clk);
        check(host_rst, 16'h0000);
        rd(PULLUP_SEL_OFFSET, 8'h11);
        $display("bus reset test done");
        wr(CONFIG_OFFSET, 8'h41);
        repeat (2) @(negedge clk);
        check(sync_oe, 16'h0001);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check(sync_oe, 16'h0000);
        rd(CONFIG_OFFSET, CONFIG_RESET);
        $display("mid-run reset test done");
        give_verdict();
    end
endmodule : matrix_sync_shutdown_test_ctrl_tb_top
